// ===== bench/dar_host_model.sv
// Purpose: APB host model standing in for the processor
// Assumes: slave may add wait states; answer taken on a rising edge
// Notes: released address and data show the inverse of the last value
`timescale 1ns/100ps
module dar_host_model
    import dar_pkg::*;
(
    input wire logic clock,
    output logic [ADDR_W-1:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output int tmo
);
    initial begin
        {paddr, psel, penable, pwrite, pwdata} = '0;
        tmo = 0;
    end
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = pslverr;
        if (pready !== 1'b1) tmo = 1;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // dar_host_model

// ===== bench/dar_regs_checker.sv
// Purpose: Port-level assertions for the channel A register block
// Assumes: zero-wait APB slave; outputs lag their source flop by one cycle
// Notes: output, mask, vector, preset and auxiliary control registers are shadowed from APB traffic
`timescale 1ns/100ps
module dar_regs_checker
    import dar_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic chanARequestToSendN,
    input wire logic irqN,
    input wire logic baudSetSel,
    input wire logic [15:0] counterPreset,
    input wire logic [7:0] interruptVector,
    input wire logic rxResetCmd
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic [7:0] oprR, imrR, ivrR, hiR, loR, acrR;
    wire logic wrDone = psel && penable && pready && pwrite;
    wire logic cmdRxReset = wrDone && paddr == OFF_CMD && pwdata[CMD_HI:CMD_LO] == CMD_RX_RESET;
    // Shadows reset with the design so $past agrees after any reset
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            {oprR, imrR, ivrR, hiR, loR, acrR} <= '0;
        end else if (wrDone) begin
            if (paddr == OFF_OPR) oprR <= pwdata[7:0];
            if (paddr == OFF_IMR) imrR <= pwdata[7:0];
            if (paddr == OFF_IVR) ivrR <= pwdata[7:0];
            if (paddr == OFF_COUNTER_PRESET_HIGH) hiR <= pwdata[7:0];
            if (paddr == OFF_COUNTER_PRESET_LOW) loR <= pwdata[7:0];
            if (paddr == OFF_ACR) acrR <= pwdata[7:0];
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    a_ready_cause: assert property (pready |-> $past(psel && !penable))
        else $error("ready without setup");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error outside ready");
    a_rdata_upper: assert property (prdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_rts_manual: assert property (!chanARequestToSendN |-> $past(oprR[0]))
        else $error("request to send low with output bit clear");
    a_baud_sel: assert property (baudSetSel == $past(acrR[ACR_BRG_BIT]))
        else $error("baud set select wrong");
    a_preset_join: assert property (counterPreset == $past({hiR, loR}))
        else $error("counter preset wrong");
    a_vector_out: assert property (interruptVector == $past(ivrR))
        else $error("vector output wrong");
    a_irq_masked: assert property ($past(imrR) == 8'h0 && $past(imrR, 2) == 8'h0 |-> irqN)
        else $error("interrupt with all masked");
    a_rx_reset_pulse: assert property (rxResetCmd == $past(cmdRxReset))
        else $error("receiver reset pulse wrong");
endmodule // dar_regs_checker

// ===== bench/tb.sv
// Purpose: Self-checking bench for the channel A mode and interrupt registers
// Assumes: host model speaks APB; bench drives the receiver side flags
// Notes: expectations come from a small integer model
`timescale 1ns/100ps
module tb;
    import dar_pkg::*;
    logic clock, rst_b, psel, penable, pwrite, pready, pslverr, e;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic receiverReadyFlag, receiveFifoFullFlag, rxValidStart, rxTopArrive, rxTopValid;
    logic chanATransmitReady, chanABreakChange, chanBBreakChange, chanBRxIntSrc;
    logic chanBTransmitReady, counterReady, chanARequestToSendN, outPortBit4, irqN;
    logic chanARxIntSrc, baudSetSel, rxResetCmd;
    logic [IN_CHG_W-1:0] inPortPins;
    logic [7:0] chanAModeSecond, auxControl, interruptVector;
    logic [15:0] counterPreset;
    dar_err_t rxTopErr, chanAErrStatus;
    dar_fmt_t chanAFormat;
    int error_cnt, checked, tmo, m, c;

    dar_chan_a_regs dut (.*);
    dar_host_model host (.*);

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic results();
        if (tmo != 0) error_cnt++;
        $display("compares %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] x, logic [31:0] g);
        checked++;
        if (g !== x) begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", n, x, g);
        end
    endtask
    task automatic settle();
        repeat (8) @(posedge clock);
    endtask
    task automatic wr(logic [ADDR_W-1:0] a, logic [7:0] d);
        host.xfer(1'b1, a, {24'h0, d}, q, e);
        if (tmo != 0) results();
    endtask
    task automatic rd(logic [ADDR_W-1:0] a);
        host.xfer(1'b0, a, 32'h0, q, e);
        if (tmo != 0) results();
    endtask
    task automatic setM(int v);
        wr(OFF_CMD, 8'h10);
        wr(OFF_MODE, v[7:0]);
        m = v;
        settle();
    endtask
    task automatic arrive(dar_err_t f);
        rxTopErr <= f;
        rxTopArrive <= 1'b1;
        @(posedge clock);
        rxTopArrive <= 1'b0;
        @(posedge clock);
    endtask
    function automatic dar_fmt_t fmtOf(int v);
        logic [1:0] p;
        p = v[4:3];
        return {v[1:0], p == PAR_WITH || p == PAR_FORCE, p == PAR_FORCE, p == PAR_MULTI,
            p != PAR_NONE && v[2]};
    endfunction

    initial begin
        {receiverReadyFlag, receiveFifoFullFlag, rxValidStart, rxTopArrive, rxTopValid} = '0;
        {chanATransmitReady, chanABreakChange, chanBBreakChange, chanBRxIntSrc} = '0;
        {chanBTransmitReady, counterReady, inPortPins, rxTopErr} = '0;
        error_cnt = 0;
        checked = 0;
        rst_b = 1'b0;
        void'($urandom(32'hCAE6));
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        rd(OFF_ERR);
        chk("ptr", 32'h0, q);
        chk("rts", 32'h1, chanARequestToSendN);
        for (int i = 0; i < 8; i++) begin
            setM((i << 2) | ($urandom & 3));
            chk("fmt", fmtOf(m), chanAFormat);
        end
        rd(OFF_ERR);
        chk("ptr", 32'h8, q);
        wr(OFF_MODE, 8'h5A);
        rd(OFF_MODE);
        chk("mode2", 32'h5A, q);
        chk("mode2out", 32'h5A, chanAModeSecond);
        chk("fmt", fmtOf(m), chanAFormat);
        wr(OFF_CMD, 8'h10);
        rd(OFF_MODE);
        chk("mode1", m, q);
        rd(OFF_MODE);
        chk("mode2", 32'h5A, q);
        setM(8'h80);
        wr(OFF_OPR, 8'h01);
        settle();
        chk("rts", 32'h0, chanARequestToSendN);
        receiveFifoFullFlag <= 1'b1;
        rxValidStart <= 1'b1;
        @(posedge clock);
        rxValidStart <= 1'b0;
        settle();
        chk("rts", 32'h1, chanARequestToSendN);
        rd(OFF_OPR);
        chk("opr", 32'h1, q);
        receiveFifoFullFlag <= 1'b0;
        settle();
        chk("rts", 32'h0, chanARequestToSendN);
        receiverReadyFlag <= 1'b1;
        wr(OFF_OUTPUT_PORT_CONFIG, 8'h10);
        for (int j = 0; j < 2; j++) begin
            setM(j << 6);
            chk("rxsrc", 32'(j == 0), chanARxIntSrc);
            chk("op4", 32'(j != 0), outPortBit4);
        end
        c = ($urandom & 8'h7D) | 8'h80;
        {chanBBreakChange, chanBRxIntSrc, chanBTransmitReady, counterReady} <= c[6:3];
        chanABreakChange <= c[2];
        chanATransmitReady <= c[0];
        wr(OFF_ACR, 8'h84);
        inPortPins <= 4'h4;
        settle();
        chk("baud", 32'h1, baudSetSel);
        chk("acr", 32'h84, auxControl);
        rd(OFF_ISR);
        chk("isr", c, q);
        for (int k = 0; k < 8; k++) begin
            wr(OFF_IMR, 8'(1 << k));
            settle();
            chk("irq", 32'(!c[k]), irqN);
        end
        rd(OFF_INPUT_CHANGE_STATUS);
        chk("input_change_status", 32'h44, q);
        rd(OFF_INPUT_CHANGE_STATUS);
        chk("input_change_status", 32'h04, q);
        rxTopValid <= 1'b1;
        rxTopErr <= 3'b101;
        settle();
        chk("err", 32'h5, chanAErrStatus);
        setM(8'h20);
        arrive(3'b100);
        arrive(3'b001);
        settle();
        chk("err", 32'h5, chanAErrStatus);
        rd(OFF_ERR);
        chk("errreg", 32'hD, q);
        wr(OFF_CMD, 8'h40);
        settle();
        chk("err", 32'h0, chanAErrStatus);
        arrive(3'b010);
        wr(OFF_CMD, 8'h20);
        settle();
        chk("err", 32'h0, chanAErrStatus);
        c = $urandom;
        wr(OFF_COUNTER_PRESET_HIGH, c[15:8]);
        wr(OFF_COUNTER_PRESET_LOW, c[7:0]);
        wr(OFF_IVR, c[23:16]);
        rd(OFF_IVR);
        chk("ivr", c[23:16], q);
        chk("preset", c[15:0], counterPreset);
        rd(OFF_IMR);
        chk("wo", 32'h0, q);
        rd(8'h30);
        chk("slverr", 32'h1, e);
        results();
    end
endmodule // tb

bind dar_chan_a_regs dar_regs_checker chk_i (.*);

// ===== hdl/dar_chan_a_regs.sv
// Purpose: Channel A mode register 1 logic plus shared interrupt, input change,
//          counter preset and vector registers, behind an APB slave
// Assumes: Receiver, transmitter and counter live outside and exchange flags here
// Notes: Zero-wait APB; one cycle setup, answer in the first access cycle
//
// Behaviour
// - Mode address reaches mode register 1 while channel A pointer selects first.
// - Reset and set-pointer command force pointer back to mode register 1.
// - Any read or write of mode register 1 moves pointer to second.
// - Request-to-send pin follows output register bit 0 set and clear.
// - With bit 7 set, valid start into full FIFO negates request-to-send.
// - Flow negation leaves output bit 0 alone; reasserts when FIFO frees.
// - Mode bit 6 picks ready or FIFO-full as receiver interrupt source.
// - Output bit 4 configured as interrupt carries the mode bit 6 choice.
// - Character error mode: break, framing, parity describe FIFO top only.
// - Block error mode: those bits OR every top character since reset-error or receiver reset.
// - With or forced parity: transmitter adds parity, receiver checks it.
// - Parity field 11 selects multidrop with address/data marker bit.
// - With-parity mode: bit 2 chooses odd or even parity.
// - Forced-parity mode: bit 2 is the fixed parity bit value.
// - Parity type bit ignored when no parity is programmed.
// - Multidrop mode: parity type bit sets address/data marker polarity.
// - Auxiliary control bit 7 selects baud set 1 clear, set 2 set.
// - Interrupt status bit layout 7,6,5,4,3,2,1,0 as listed causes.
// - Each mask bit gates the matching status bit onto interrupt output.
// - Mode bits 1:0 give 5 to 8 data bits per character.
`timescale 1ns/100ps
module dar_chan_a_regs
    import dar_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    // APB
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receiver side flags
    input wire logic receiverReadyFlag,
    input wire logic receiveFifoFullFlag,
    input wire logic rxValidStart,
    input wire logic rxTopArrive,
    input wire logic rxTopValid,
    input wire dar_err_t rxTopErr,
    // Other interrupt causes
    input wire logic chanATransmitReady,
    input wire logic chanABreakChange,
    input wire logic chanBBreakChange,
    input wire logic chanBRxIntSrc,
    input wire logic chanBTransmitReady,
    input wire logic counterReady,
    input wire logic [IN_CHG_W-1:0] inPortPins,
    // Outputs
    output logic chanARequestToSendN,
    output logic outPortBit4,
    output logic irqN,
    output dar_fmt_t chanAFormat,
    output dar_err_t chanAErrStatus,
    output logic chanARxIntSrc,
    output logic [7:0] chanAModeSecond,
    output logic baudSetSel,
    output logic [7:0] auxControl,
    output logic [15:0] counterPreset,
    output logic [7:0] interruptVector,
    output logic rxResetCmd
);

    // APB decode
    wire logic setupPhase = psel & ~penable;
    wire logic accessDone = psel & penable & pready;
    wire logic wrDone = accessDone & pwrite;
    wire logic rdDone = accessDone & ~pwrite;
    wire logic hitMode = (paddr == OFF_MODE);
    wire logic hitCmd = (paddr == OFF_CMD);
    wire logic hitOpr = (paddr == OFF_OPR);
    wire logic hitOpcr = (paddr == OFF_OUTPUT_PORT_CONFIG);
    wire logic hitAcr = (paddr == OFF_ACR);
    wire logic hitIpcr = (paddr == OFF_INPUT_CHANGE_STATUS);
    wire logic hitIsr = (paddr == OFF_ISR);
    wire logic hitImr = (paddr == OFF_IMR);
    wire logic hitCtur = (paddr == OFF_COUNTER_PRESET_HIGH);
    wire logic hitCtlr = (paddr == OFF_COUNTER_PRESET_LOW);
    wire logic hitIvr = (paddr == OFF_IVR);
    wire logic hitErr = (paddr == OFF_ERR);
    wire logic hitAny = hitMode | hitCmd | hitOpr | hitOpcr | hitAcr | hitIpcr
        | hitIsr | hitImr | hitCtur | hitCtlr | hitIvr | hitErr;
    wire logic [7:0] wByte = pwdata[7:0];

    logic [7:0] modeFirst_r;
    logic [7:0] modeSecond_r;
    dar_ptr_t ptr_r;
    logic [7:0] opr_r;
    logic [7:0] output_port_config_r;
    logic [7:0] acr_r;
    logic [7:0] imr_r;
    logic [7:0] counter_preset_high_r;
    logic [7:0] counter_preset_low_r;
    logic [7:0] ivr_r;
    logic flowHold_r;
    dar_err_t errAcc_r;
    logic [IN_CHG_W-1:0] ipS1_r;
    logic [IN_CHG_W-1:0] ipS2_r;
    logic [IN_CHG_W-1:0] ipS3_r;
    logic [IN_CHG_W-1:0] ipLevel_r;
    logic [IN_CHG_W-1:0] ipDelta_r;

    // Mode register addressing through the pointer
    wire logic modeAccess = accessDone & hitMode;
    wire logic modeFirstSel = (ptr_r == PTR_FIRST);
    wire logic modeFirstWr = wrDone & hitMode & modeFirstSel;
    wire logic modeSecondWr = wrDone & hitMode & ~modeFirstSel;
    wire logic [2:0] cmdCode = wByte[CMD_HI:CMD_LO];
    wire logic cmdWr = wrDone & hitCmd;
    wire logic setPtrCmd = cmdWr & (cmdCode == CMD_SET_PTR);
    wire logic errResetCmd = cmdWr & (cmdCode == CMD_ERR_RESET);
    wire logic rxRstCmd = cmdWr & (cmdCode == CMD_RX_RESET);

    // Format decode
    wire logic [1:0] parMode = modeFirst_r[M1_PAR_HI:M1_PAR_LO];
    wire logic parEn = (parMode == PAR_WITH) | (parMode == PAR_FORCE);
    wire logic parMulti = (parMode == PAR_MULTI);
    wire logic parTypeUsed = modeFirst_r[M1_PAR_TYPE] & (parMode != PAR_NONE);
    wire dar_fmt_t fmtNxt = '{charLen: modeFirst_r[M1_LEN_HI:M1_LEN_LO],
                              parityEn: parEn,
                              parityForced: (parMode == PAR_FORCE),
                              multidrop: parMulti,
                              parityType: parTypeUsed};

    // Receiver interrupt source
    wire logic rxIntNxt = modeFirst_r[M1_RX_INT_SEL] ? receiveFifoFullFlag
        : receiverReadyFlag;

    // Flow control hold: set on start into full FIFO, dropped once a slot frees
    wire logic flowSet = modeFirst_r[M1_RX_RTS] & rxValidStart & receiveFifoFullFlag;
    wire logic flowHoldNxt = flowSet | (flowHold_r & receiveFifoFullFlag);
    // Pin is inverse of the output bit while no flow hold is active
    wire logic rtsPinNxt = ~(opr_r[OP_RTS_BIT] & ~flowHoldNxt);

    // Bit 4 pin: open-drain style interrupt is active low like the port bits
    wire logic op4Nxt = output_port_config_r[OP_IRQ_BIT] ? ~rxIntNxt : ~opr_r[OP_IRQ_BIT];

    // Error status
    wire logic errClr = errResetCmd | rxRstCmd;
    wire dar_err_t topErr = rxTopValid ? rxTopErr : dar_err_t'(3'h0);
    wire dar_err_t arriveErr = rxTopArrive ? rxTopErr : dar_err_t'(3'h0);
    // Set beats clear in the same cycle
    wire dar_err_t errAccNxt = arriveErr | (errClr ? dar_err_t'(3'h0) : errAcc_r);
    wire dar_err_t errOutNxt = modeFirst_r[M1_ERR_MODE] ? errAccNxt : topErr;

    // Input change detection: a change counts when stages two and three agree
    wire logic [IN_CHG_W-1:0] ipStable = ~(ipS2_r ^ ipS3_r);
    wire logic [IN_CHG_W-1:0] ipChange = ipStable & (ipS3_r ^ ipLevel_r);
    wire logic [IN_CHG_W-1:0] ipLevelNxt = (ipStable & ipS3_r) | (~ipStable & ipLevel_r);
    wire logic ipcrRead = rdDone & hitIpcr;
    // New change wins over clear-on-read
    wire logic [IN_CHG_W-1:0] ipDeltaNxt = ipChange | (ipcrRead ? RST_NIB : ipDelta_r);
    wire logic [7:0] ipcrView = {ipDelta_r, ipLevel_r};
    wire logic inChangeInt = |(ipDelta_r & acr_r[IN_CHG_W-1:0]);

    // Interrupt status layout
    wire logic [7:0] isrView = {inChangeInt, chanBBreakChange, chanBRxIntSrc,
                                chanBTransmitReady, counterReady, chanABreakChange,
                                rxIntNxt, chanATransmitReady};
    wire logic irqNxt = ~|(isrView & imr_r);

    wire logic [7:0] modeView = modeFirstSel ? modeFirst_r : modeSecond_r;
    wire logic [7:0] errView = {4'h0, ptr_r == PTR_SECOND, errOutNxt};
    wire logic [7:0] rdByte = hitMode ? modeView
        : hitOpr ? opr_r
        : hitOpcr ? output_port_config_r
        : hitIpcr ? ipcrView
        : hitIsr ? isrView
        : hitIvr ? ivr_r
        : hitErr ? errView
        : RST_BYTE;

    // APB handshake: answer in the first access cycle
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setupPhase;
            pslverr <= setupPhase & ~hitAny;
            if (setupPhase) begin
                prdata <= {24'h00_0000, pwrite ? RST_BYTE : rdByte};
            end
        end
    end

    // Mode pointer
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ptr_r <= PTR_FIRST;
        end else if (setPtrCmd) begin
            ptr_r <= PTR_FIRST;
        end else if (modeAccess & modeFirstSel) begin
            ptr_r <= PTR_SECOND;
        end
    end

    // Write registers
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            modeFirst_r <= RST_BYTE;
            modeSecond_r <= RST_BYTE;
            opr_r <= RST_BYTE;
            output_port_config_r <= RST_BYTE;
            acr_r <= RST_BYTE;
            imr_r <= RST_BYTE;
            counter_preset_high_r <= RST_BYTE;
            counter_preset_low_r <= RST_BYTE;
            ivr_r <= RST_BYTE;
        end else begin
            if (modeFirstWr) modeFirst_r <= wByte;
            if (modeSecondWr) modeSecond_r <= wByte;
            if (wrDone & hitOpr) opr_r <= wByte;
            if (wrDone & hitOpcr) output_port_config_r <= wByte;
            if (wrDone & hitAcr) acr_r <= wByte;
            if (wrDone & hitImr) imr_r <= wByte;
            if (wrDone & hitCtur) counter_preset_high_r <= wByte;
            if (wrDone & hitCtlr) counter_preset_low_r <= wByte;
            if (wrDone & hitIvr) ivr_r <= wByte;
        end
    end

    // Flow hold and error accumulation
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            flowHold_r <= 1'b0;
            errAcc_r <= dar_err_t'(3'h0);
        end else begin
            flowHold_r <= flowHoldNxt;
            errAcc_r <= errAccNxt;
        end
    end

    // Input pin synchroniser, three stages
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ipS1_r <= RST_NIB;
            ipS2_r <= RST_NIB;
            ipS3_r <= RST_NIB;
            ipLevel_r <= RST_NIB;
            ipDelta_r <= RST_NIB;
        end else begin
            ipS1_r <= inPortPins;
            ipS2_r <= ipS1_r;
            ipS3_r <= ipS2_r;
            ipLevel_r <= ipLevelNxt;
            ipDelta_r <= ipDeltaNxt;
        end
    end

    // Registered outputs
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            chanARequestToSendN <= 1'b1;
            outPortBit4 <= 1'b1;
            irqN <= 1'b1;
            chanAFormat <= dar_fmt_t'(6'h00);
            chanAErrStatus <= dar_err_t'(3'h0);
            chanARxIntSrc <= 1'b0;
            chanAModeSecond <= RST_BYTE;
            baudSetSel <= 1'b0;
            auxControl <= RST_BYTE;
            counterPreset <= 16'h0000;
            interruptVector <= RST_BYTE;
            rxResetCmd <= 1'b0;
        end else begin
            chanARequestToSendN <= rtsPinNxt;
            outPortBit4 <= op4Nxt;
            irqN <= irqNxt;
            chanAFormat <= fmtNxt;
            chanAErrStatus <= errOutNxt;
            chanARxIntSrc <= rxIntNxt;
            chanAModeSecond <= modeSecond_r;
            baudSetSel <= acr_r[ACR_BRG_BIT];
            auxControl <= acr_r;
            counterPreset <= {counter_preset_high_r, counter_preset_low_r};
            interruptVector <= ivr_r;
            rxResetCmd <= rxRstCmd;
        end
    end

endmodule // dar_chan_a_regs

// ===== hdl/dar_pkg.sv
// Purpose: Shared constants and types for the channel A mode and interrupt register block
// Assumes: APB slave, 32-bit data, one aligned word per 8-bit register
// Notes: Register offsets are byte addresses
package dar_pkg;

    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_MODE = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CMD = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_OPR = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_OUTPUT_PORT_CONFIG = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_ACR = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_INPUT_CHANGE_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_ISR = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_IMR = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_COUNTER_PRESET_HIGH = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_COUNTER_PRESET_LOW = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_IVR = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_ERR = 8'h2C;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_NIB = 4'h0;

    // Mode register 1 fields
    localparam int M1_RX_RTS = 7;
    localparam int M1_RX_INT_SEL = 6;
    localparam int M1_ERR_MODE = 5;
    localparam int M1_PAR_HI = 4;
    localparam int M1_PAR_LO = 3;
    localparam int M1_PAR_TYPE = 2;
    localparam int M1_LEN_HI = 1;
    localparam int M1_LEN_LO = 0;

    localparam logic [1:0] PAR_WITH = 2'h0;
    localparam logic [1:0] PAR_FORCE = 2'h1;
    localparam logic [1:0] PAR_NONE = 2'h2;
    localparam logic [1:0] PAR_MULTI = 2'h3;

    // Command register miscellaneous field
    localparam int CMD_HI = 6;
    localparam int CMD_LO = 4;
    localparam logic [2:0] CMD_SET_PTR = 3'h1;
    localparam logic [2:0] CMD_RX_RESET = 3'h2;
    localparam logic [2:0] CMD_ERR_RESET = 3'h4;

    // Bit positions
    localparam int OP_RTS_BIT = 0;
    localparam int OP_IRQ_BIT = 4;
    localparam int ACR_BRG_BIT = 7;
    localparam int IN_CHG_W = 4;

    typedef enum logic {PTR_FIRST, PTR_SECOND} dar_ptr_t;

    typedef struct packed {
        logic [1:0] charLen;
        logic parityEn;
        logic parityForced;
        logic multidrop;
        logic parityType;
    } dar_fmt_t;

    typedef struct packed {
        logic brk;
        logic frm;
        logic par;
    } dar_err_t;

endpackage
